// File: ecs_cmd.sv
// command decoder for endpoint status, setup acknowledge and scratch
`timescale 1ns/1ns
`include "ecs_map.svh"

module ecs_cmd #(
	parameter int NUM_EP = 16
) (
	input  wire logic                   clk_i,         // 100 MHz clock
	input  wire logic                   rst_b_i,       // async reset, low
	input  wire ecs_pkg::ecs_host_pins_t host_i,       // host port pins
	output logic [7:0]                  data_o,        // read data to pins
	output logic                        data_oe_o,     // drive data pins
	input  wire logic [NUM_EP-1:0]      full1_i,       // secondary full
	input  wire logic [NUM_EP-1:0]      full0_i,       // primary full
	input  wire logic [NUM_EP-1:0]      toggle_i,      // next data toggle
	input  wire logic [NUM_EP-1:0]      setup_held_i,  // setup in buffer
	input  wire logic [NUM_EP-1:0]      buf_select_i,  // cpu buffer select
	input  wire logic [NUM_EP-1:0]      ep_event_i,    // endpoint events
	input  wire logic                   setup_rx_i,    // setup token pulse
	input  wire logic                   setup_done_i,  // setup data written
	output logic [NUM_EP-1:0]           ep_irq_o,      // interrupt bits
	output logic [NUM_EP-1:0]           stall_o,       // stalled endpoints
	output logic                        validate_o,    // validate pulse
	output logic                        clear_o,       // clear pulse
	output logic [3:0]                  buf_ep_o,      // buffer cmd target
	output logic                        setup_ack_o,   // setup ack pulse
	output logic                        setup_block_o, // ctrl cmds blocked
	output logic                        dma_on_o       // dma function on
);
	import ecs_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// sixteen command codes per group address exactly sixteen endpoints
	if (NUM_EP != 16) begin : g_bad_ep
		$error("ecs_cmd serves exactly sixteen endpoints");
	end

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_ff1;
	logic rst_b;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_ff1 <= 1'b0;
			rst_b   <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_b   <= rst_ff1;
		end
	end

	// ----------------------------------------------------------------
	// host pin synchronisers
	// ----------------------------------------------------------------
	localparam ecs_host_pins_t PINS_IDLE = '{
		cmd_sel : 1'b0,
		wr_b    : 1'b1,
		rd_b    : 1'b1,
		data    : `ECS_BYTE_RESET
	};

	ecs_host_pins_t pin_s1;
	ecs_host_pins_t pin_s2;
	ecs_host_pins_t pin_prev;

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1   <= PINS_IDLE;
			pin_s2   <= PINS_IDLE;
			pin_prev <= PINS_IDLE;
		end else begin
			pin_s1   <= host_i;
			pin_s2   <= pin_s1;
			pin_prev <= pin_s2;
		end
	end

	// a byte is taken on the release of the strobe, when data is settled
	logic wr_done;
	logic rd_done;
	logic cmd_wr;
	logic dat_wr;

	assign wr_done = pin_s2.wr_b && !pin_prev.wr_b;
	assign rd_done = pin_s2.rd_b && !pin_prev.rd_b;
	assign cmd_wr  = wr_done && pin_s2.cmd_sel;
	assign dat_wr  = wr_done && !pin_s2.cmd_sel;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic [3:0] grp;
	logic [3:0] ep;
	logic       ep_ctrl;
	logic       is_status;
	logic       is_query;
	logic       is_stall;
	logic       is_unstall;
	logic       is_valid;
	logic       is_clear;
	logic       is_ack;
	logic       is_scr_wr;
	logic       is_scr_rd;
	logic       setup_block;

	assign grp     = pin_s2.data[7:4];
	assign ep      = pin_s2.data[3:0];
	assign ep_ctrl = (ep == `ECS_EP_CTRL_OUT) || (ep == `ECS_EP_CTRL_IN);

	assign is_status  = cmd_wr && (grp == `ECS_GRP_STATUS);
	assign is_query   = cmd_wr && (grp == `ECS_GRP_QUERY);
	assign is_stall   = cmd_wr && (grp == `ECS_GRP_STALL);
	assign is_unstall = cmd_wr && (grp == `ECS_GRP_UNSTALL);
	// validate has no control OUT code, clear has no control IN code
	assign is_valid   = cmd_wr && (grp == `ECS_GRP_VALIDATE)
	                    && (ep != `ECS_EP_CTRL_OUT);
	assign is_clear   = cmd_wr && (grp == `ECS_GRP_CLEAR)
	                    && (ep != `ECS_EP_CTRL_IN);
	assign is_ack     = cmd_wr && (pin_s2.data == `ECS_CMD_SETUP_ACK);
	assign is_scr_wr  = cmd_wr && (pin_s2.data == `ECS_CMD_SCR_WRITE);
	assign is_scr_rd  = cmd_wr && (pin_s2.data == `ECS_CMD_SCR_READ);

	// ----------------------------------------------------------------
	// per endpoint flags and status image
	// ----------------------------------------------------------------
	logic           [NUM_EP-1:0] stall;
	logic           [NUM_EP-1:0] irq;
	logic           [NUM_EP-1:0] replaced;
	logic                        setup_pending;
	ecs_ep_status_t              image [NUM_EP];

	for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
		logic hit;
		logic ctrl;

		assign hit  = (ep == 4'(e));
		assign ctrl = (e == 0) || (e == 1);

		// a stall command wins over an unstall by a setup token
		always_ff @(posedge clk_i or negedge rst_b) begin
			if (!rst_b) begin
				stall[e] <= 1'b0;
			end else if (is_stall && hit) begin
				stall[e] <= 1'b1;
			end else if (is_unstall && hit) begin
				stall[e] <= 1'b0;
			end else if (ctrl && setup_rx_i) begin
				stall[e] <= 1'b0;
			end
		end

		// event set wins over the clear by a status read
		always_ff @(posedge clk_i or negedge rst_b) begin
			if (!rst_b) begin
				irq[e] <= 1'b0;
			end else if (ep_event_i[e]) begin
				irq[e] <= 1'b1;
			end else if (is_status && hit) begin
				irq[e] <= 1'b0;
			end
		end

		// only the control endpoints can see setup data replaced
		always_ff @(posedge clk_i or negedge rst_b) begin
			if (!rst_b) begin
				replaced[e] <= 1'b0;
			end else if (ctrl && setup_rx_i && setup_pending) begin
				replaced[e] <= 1'b1;
			end else if (is_status && hit && setup_done_i) begin
				replaced[e] <= 1'b0;
			end
		end

		always_comb begin
			image[e].stall_flag              = stall[e];
			image[e].secondary_buffer_full   = full1_i[e];
			image[e].primary_buffer_full     = full0_i[e];
			image[e].next_data_toggle        = toggle_i[e];
			image[e].setup_replaced_flag     = replaced[e];
			image[e].setup_packet_held       = setup_held_i[e];
			image[e].processor_buffer_select = buf_select_i[e];
			image[e].unused                  = 1'b0;
		end
	end

	// setup data stays open to setup_replaced_flag until acknowledged or stalled
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			setup_pending <= 1'b0;
		end else if (setup_rx_i) begin
			setup_pending <= 1'b1;
		end else if (is_ack || (is_stall && ep_ctrl)) begin
			setup_pending <= 1'b0;
		end
	end

	// a fresh setup wins over an acknowledge in the same cycle
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			setup_block <= 1'b0;
		end else if (setup_rx_i) begin
			setup_block <= 1'b1;
		end else if (is_ack) begin
			setup_block <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// buffer command and acknowledge pulses
	// ----------------------------------------------------------------
	logic buf_blocked;

	assign buf_blocked = setup_block && ep_ctrl;

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			validate_o  <= 1'b0;
			clear_o     <= 1'b0;
			buf_ep_o    <= `ECS_EP_CTRL_OUT;
			setup_ack_o <= 1'b0;
		end else begin
			validate_o  <= is_valid && !buf_blocked;
			clear_o     <= is_clear && !buf_blocked;
			setup_ack_o <= is_ack;
			if (is_valid || is_clear) begin
				buf_ep_o <= ep;
			end
		end
	end

	// ----------------------------------------------------------------
	// transfer sequencer
	// ----------------------------------------------------------------
	ecs_state_t state;
	ecs_state_t next_state;
	logic       idx;
	logic       last_idx;
	logic [7:0] low_hold;
	logic [15:0] scratch;

	// a command byte always aborts any transfer in progress
	always_comb begin
		next_state = state;
		case (state)
			ECS_IDLE: begin
				next_state = ECS_IDLE;
			end
			ECS_WRITE: begin
				if (dat_wr && idx == `ECS_IDX_SECOND) begin
					next_state = ECS_IDLE;
				end
			end
			ECS_READ: begin
				if (rd_done && idx == last_idx) begin
					next_state = ECS_IDLE;
				end
			end
			default: begin
				next_state = ECS_IDLE;
			end
		endcase
		if (is_scr_wr) begin
			next_state = ECS_WRITE;
		end else if (is_scr_rd || is_status || is_query) begin
			next_state = ECS_READ;
		end else if (cmd_wr) begin
			next_state = ECS_IDLE;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			state <= ECS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			idx      <= `ECS_IDX_FIRST;
			last_idx <= `ECS_IDX_FIRST;
		end else if (cmd_wr) begin
			idx      <= `ECS_IDX_FIRST;
			last_idx <= is_scr_rd ? `ECS_IDX_SECOND : `ECS_IDX_FIRST;
		end else if ((state == ECS_WRITE && dat_wr)
		             || (state == ECS_READ && rd_done)) begin
			idx <= !idx;
		end
	end

	// ----------------------------------------------------------------
	// function and scratch register
	// ----------------------------------------------------------------
	// low byte is held back so a half-written word never steers the dma
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			low_hold <= `ECS_BYTE_RESET;
			scratch  <= `ECS_SCR_RESET;
		end else if (state == ECS_WRITE && dat_wr) begin
			if (idx == `ECS_IDX_FIRST) begin
				low_hold <= pin_s2.data;
			end else begin
				scratch <= {pin_s2.data, low_hold};
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			dma_on_o <= 1'b0;
		end else if (state == ECS_WRITE && dat_wr
		             && idx == `ECS_IDX_SECOND) begin
			dma_on_o <= pin_s2.data[`ECS_DMA_ON_BIT-8];
		end
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	// the query image is captured at decode; nothing else is touched
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			data_o <= `ECS_BYTE_RESET;
		end else if (is_status || is_query) begin
			data_o <= image[ep];
		end else if (is_scr_rd) begin
			data_o <= scratch[7:0];
		end else if (state == ECS_READ && rd_done
		             && idx == `ECS_IDX_FIRST && last_idx) begin
			data_o <= scratch[15:8];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			data_oe_o <= 1'b0;
		end else begin
			data_oe_o <= (state == ECS_READ) && !pin_s2.rd_b
			             && !pin_s2.cmd_sel;
		end
	end

	// ----------------------------------------------------------------
	// flag outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b) begin
		if (!rst_b) begin
			ep_irq_o      <= '0;
			stall_o       <= '0;
			setup_block_o <= 1'b0;
		end else begin
			ep_irq_o      <= irq;
			stall_o       <= stall;
			setup_block_o <= setup_block;
		end
	end

endmodule : ecs_cmd

// File: ecs_map.svh
// command codes, field positions and reset values of the command slice
// Behaviour
// - status query codes D0h-DFh pick control OUT, IN, endpoints 1-14; return one byte
// - the status query changes no status bit and no interrupt bit
// - returned image byte mirrors the endpoint status register bit for bit
// - bit 7 reads one while the endpoint is stalled
// - bit 6 secondary buffer full, bit 5 primary buffer full
// - bit 4 gives next expected data toggle, 0 DATA0, 1 DATA1
// - bit 3 sets when a new setup overwrites unacknowledged, unstalled setup data
// - bit 2 reads one while the buffer holds a setup packet
// - bit 1 shows the buffer assigned to processor access
// - acknowledge setup code F4h is taken with no data phase
// - a setup packet blocks validate and clear on both control endpoints
// - function and scratch register written with B2h, read with B3h, two bytes
// - function and scratch register is sixteen bits, read-write, reset zero
// - writing one to bit 15 turns the DMA function on
// - bits 12-8 and 7-0 hold scratch data returned unchanged
// - ordinary status read 50h-5Fh clears that endpoint's interrupt bit
// - a setup token unstalls a stalled control endpoint
`ifndef ECS_MAP_SVH
`define ECS_MAP_SVH

`define ECS_GRP_STALL      4'h4
`define ECS_GRP_STATUS     4'h5
`define ECS_GRP_VALIDATE   4'h6
`define ECS_GRP_CLEAR      4'h7
`define ECS_GRP_UNSTALL    4'h8
`define ECS_GRP_QUERY      4'hD
`define ECS_CMD_SETUP_ACK  8'hF4
`define ECS_CMD_SCR_WRITE  8'hB2
`define ECS_CMD_SCR_READ   8'hB3
`define ECS_EP_CTRL_OUT    4'h0
`define ECS_EP_CTRL_IN     4'h1
`define ECS_DMA_ON_BIT     15
`define ECS_SCR_RESET      16'h0000
`define ECS_BYTE_RESET     8'h00
`define ECS_IDX_FIRST      1'b0
`define ECS_IDX_SECOND     1'b1

`endif

// File: ecs_pkg.sv
// types shared by the endpoint status, setup and scratch command slice
package ecs_pkg;

	typedef enum logic [2:0] {
		ECS_IDLE  = 3'b001,
		ECS_WRITE = 3'b010,
		ECS_READ  = 3'b100
	} ecs_state_t;

	// one status image byte, msb first
	typedef struct packed {
		logic stall_flag;
		logic secondary_buffer_full;
		logic primary_buffer_full;
		logic next_data_toggle;
		logic setup_replaced_flag;
		logic setup_packet_held;
		logic processor_buffer_select;
		logic unused;
	} ecs_ep_status_t;

	// parallel host port pins, as seen after synchronisation
	typedef struct packed {
		logic       cmd_sel;
		logic       wr_b;
		logic       rd_b;
		logic [7:0] data;
	} ecs_host_pins_t;

endpackage : ecs_pkg

// File: ecs_cmd_properties.sv
// concurrent checks on the ports of the command slice
`timescale 1ns/1ns
module ecs_cmd_properties #(
	parameter int NUM_EP = 16
) (
	input wire logic                    clk_i,         // clock
	input wire logic                    rst_b_i,       // reset, low
	input wire ecs_pkg::ecs_host_pins_t host_i,        // host pins
	input wire logic                    data_oe_o,     // data drive
	input wire logic [NUM_EP-1:0]       stall_o,       // stall bits
	input wire logic                    setup_rx_i,    // setup pulse
	input wire logic                    validate_o,    // validate pulse
	input wire logic                    clear_o,       // clear pulse
	input wire logic [3:0]              buf_ep_o,      // buffer target
	input wire logic                    setup_ack_o,   // ack pulse
	input wire logic                    setup_block_o, // ctrl blocked
	input wire logic                    dma_on_o       // dma on
);
	import ecs_pkg::*;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// the synchroniser delays release, so a margin past three is taken
	sequence s_rd_idle;
		host_i.rd_b [*6];
	endsequence
	sequence s_blocked;
		setup_block_o && $past(setup_block_o);
	endsequence

	a_oe_needs_rd: assert property (
		$rose(data_oe_o) |-> !host_i.rd_b && !$past(host_i.rd_b))
		else $error("data driven without read strobe");
	a_oe_released: assert property (s_rd_idle |-> !data_oe_o)
		else $error("data still driven after read");
	a_dma_on_write: assert property (
		$changed(dma_on_o) |-> host_i.wr_b && !host_i.cmd_sel)
		else $error("dma bit moved outside a data write");
	a_setup_blocks: assert property (
		setup_rx_i |-> ##[1:3] setup_block_o)
		else $error("setup did not block buffer commands");
	a_setup_unstall: assert property (
		setup_rx_i |-> ##[1:3] (stall_o[1:0] == 2'b00))
		else $error("setup left control endpoint stalled");
	a_block_ctrl_buf: assert property (
		s_blocked ##0 (validate_o || clear_o) |-> buf_ep_o > 4'h1)
		else $error("control buffer command while blocked");
	a_ack_unblocks: assert property (
		setup_ack_o && !$past(setup_rx_i) |=> !setup_block_o)
		else $error("acknowledge did not unblock");
	a_ack_single: assert property (setup_ack_o |=> !setup_ack_o)
		else $error("acknowledge pulse too long");
endmodule : ecs_cmd_properties

bind ecs_cmd ecs_cmd_properties #(.NUM_EP(NUM_EP)) u_props (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .host_i(host_i),
	.data_oe_o(data_oe_o), .stall_o(stall_o), .setup_rx_i(setup_rx_i),
	.validate_o(validate_o), .clear_o(clear_o), .buf_ep_o(buf_ep_o),
	.setup_ack_o(setup_ack_o), .setup_block_o(setup_block_o),
	.dma_on_o(dma_on_o));

// File: ecs_host_model.sv
// host processor model driving the parallel command port
`timescale 1ns/1ns
module ecs_host_model (
	input  wire logic              clk_i,     // clock
	input  wire logic [7:0]        data_o,    // device read byte
	input  wire logic              data_oe_o, // device drives data
	output ecs_pkg::ecs_host_pins_t host_o     // pins to device
);
	import ecs_pkg::*;
	logic       cs;
	logic       wr_b;
	logic       rd_b;
	logic [7:0] hd;

	// released bus keeps the written byte six clocks past the strobe, then shows its inverse
	assign host_o = {cs, wr_b, rd_b, (data_oe_o ? data_o : hd)};
	initial begin
		cs = 1'b0;
		wr_b = 1'b1;
		rd_b = 1'b1;
		hd = 8'h00;
	end
	// ----------------------------------------
	// strobes of at least three clocks each
	// ----------------------------------------
	task automatic wr(input logic c, input logic [7:0] d);
		@(posedge clk_i);
		cs <= c;
		hd <= d;
		wr_b <= 1'b0;
		repeat (3) @(posedge clk_i);
		wr_b <= 1'b1;
		repeat (6) @(posedge clk_i);
		hd <= ~d;
	endtask : wr
	task automatic rd(output logic [7:0] q, output logic ok);
		int n;
		@(posedge clk_i);
		cs <= 1'b0;
		rd_b <= 1'b0;
		n = 0;
		ok = 1'b0;
		while (n < 10 && !ok) begin
			@(posedge clk_i);
			n++;
			ok = (data_oe_o === 1'b1);
		end
		q = data_o;
		rd_b <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask : rd
endmodule : ecs_host_model

// File: ecs_cmd_bench.sv
// self-checking bench for the status, setup and scratch commands
`timescale 1ns/1ns
module ecs_cmd_bench;
	import ecs_pkg::*;
	logic           clk_i;
	logic           rst_b_i;
	logic           setup_rx;
	logic           done;
	logic [15:0]    full1, full0, tog, held, cpub, ev, irq, stall, v;
	ecs_host_pins_t pins;
	logic [7:0]     data_o;
	logic           data_oe_o, validate_o, clear_o, setup_ack_o, blk, dma_on;
	logic [3:0]     buf_ep;
	int             n_fail, compares, cyc, n_buf, n_ack, b0;

	ecs_cmd #(.NUM_EP(16)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.host_i(pins), .data_o(data_o), .data_oe_o(data_oe_o),
		.full1_i(full1), .full0_i(full0), .toggle_i(tog),
		.setup_held_i(held), .buf_select_i(cpub), .ep_event_i(ev),
		.setup_rx_i(setup_rx), .setup_done_i(done), .ep_irq_o(irq),
		.stall_o(stall), .validate_o(validate_o), .clear_o(clear_o),
		.buf_ep_o(buf_ep), .setup_ack_o(setup_ack_o),
		.setup_block_o(blk), .dma_on_o(dma_on));
	ecs_host_model host (.clk_i(clk_i), .data_o(data_o),
		.data_oe_o(data_oe_o), .host_o(pins));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (validate_o === 1'b1 || clear_o === 1'b1) n_buf++;
		if (setup_ack_o === 1'b1) n_ack++;
		if (cyc == 6000) begin
			n_fail++;
			summarize();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic summarize;
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd8(input logic [7:0] exp);
		logic [7:0] q;
		logic       ok;
		host.rd(q, ok);
		chk({7'h00, ok, q}, {8'h01, exp});
	endtask : rd8
	task automatic rd16(input logic [15:0] exp);
		logic [7:0] lo, hi;
		logic       ok;
		host.rd(lo, ok);
		host.rd(hi, ok);
		chk({hi, lo}, exp);
	endtask : rd16
	task automatic cmd(input logic [7:0] c);
		host.wr(1'b1, c);
	endtask : cmd
	task automatic pulse_setup;
		@(posedge clk_i);
		setup_rx <= 1'b1;
		@(posedge clk_i);
		setup_rx <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : pulse_setup
	function automatic logic [7:0] img(int k, logic stalled, logic ov);
		return {stalled, full1[k], full0[k], tog[k], ov, held[k], cpub[k],
		        1'b0};
	endfunction : img
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_b_i = 1'b0;
		setup_rx = 1'b0;
		done = 1'b1;
		{full1, full0, tog, held, cpub, ev} = '0;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		cmd(8'hB3);
		rd16(16'h0000);
		chk({15'h0000, dma_on}, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			v = i ? 16'h1FA5 : 16'h9F5A;
			cmd(8'hB2);
			host.wr(1'b0, v[7:0]);
			host.wr(1'b0, v[15:8]);
			chk({15'h0000, dma_on}, {15'h0000, v[15]});
			cmd(8'hB3);
			rd16(v);
		end
		full1 <= 16'hA5C3;
		full0 <= 16'h3C5A;
		tog <= 16'h0FF0;
		held <= 16'h0003;
		cpub <= 16'h9669;
		for (int k = 0; k < 16; k++) begin
			cmd(8'hD0 | 8'(k));
			rd8(img(k, 1'b0, 1'b0));
		end
		cmd(8'h42);
		cmd(8'hD2);
		rd8(img(2, 1'b1, 1'b0));
		cmd(8'h82);
		cmd(8'hD2);
		rd8(img(2, 1'b0, 1'b0));
		@(posedge clk_i);
		ev <= 16'h0008;
		@(posedge clk_i);
		ev <= 16'h0000;
		repeat (2) @(posedge clk_i);
		cmd(8'hD3);
		rd8(img(3, 1'b0, 1'b0));
		chk(irq, 16'h0008);
		cmd(8'h53);
		rd8(img(3, 1'b0, 1'b0));
		chk(irq, 16'h0000);
		cmd(8'h40);
		chk(stall, 16'h0001);
		pulse_setup();
		chk(stall, 16'h0000);
		chk({15'h0000, blk}, 16'h0001);
		cmd(8'hD0);
		rd8(img(0, 1'b0, 1'b0));
		b0 = n_buf;
		cmd(8'h61);
		cmd(8'h70);
		chk(16'(n_buf), 16'(b0));
		// other endpoints keep their buffer commands while control is blocked
		cmd(8'h72);
		chk(16'(n_buf), 16'(b0 + 1));
		chk({12'h000, buf_ep}, 16'h0002);
		pulse_setup();
		cmd(8'hD0);
		rd8(img(0, 1'b0, 1'b1));
		// setup data still being written: reading must not clear the flag
		done <= 1'b0;
		cmd(8'h50);
		rd8(img(0, 1'b0, 1'b1));
		cmd(8'hD0);
		rd8(img(0, 1'b0, 1'b1));
		done <= 1'b1;
		cmd(8'h50);
		rd8(img(0, 1'b0, 1'b1));
		cmd(8'hD0);
		rd8(img(0, 1'b0, 1'b0));
		cmd(8'hF4);
		chk(16'(n_ack), 16'h0001);
		chk({15'h0000, blk}, 16'h0000);
		cmd(8'h61);
		chk(16'(n_buf), 16'(b0 + 2));
		chk({12'h000, buf_ep}, 16'h0001);
		// a reset in mid-run must wipe the scratch word written above
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		cmd(8'hB3);
		rd16(16'h0000);
		chk({15'h0000, blk}, 16'h0000);
		summarize();
	end
endmodule : ecs_cmd_bench
